/* hdl/fpcs_defines.svh */
// constants for the flash protection command-set host controller
// assumes a 100 MHz sys_clk and a flash bus in 16-bit word mode by default
`ifndef FPCS_DEFINES_SVH
`define FPCS_DEFINES_SVH

// ****************************************************************
// register offsets (byte addresses on the ahb-lite slave)
// ****************************************************************
`define FPCS_OFS_CTRL    8'h00
`define FPCS_OFS_CMD     8'h04
`define FPCS_OFS_ADDR    8'h08
`define FPCS_OFS_DATA    8'h0c
`define FPCS_OFS_STATUS  8'h10
`define FPCS_OFS_RDATA   8'h14
`define FPCS_OFS_PW_LO   8'h18
`define FPCS_OFS_PW_HI   8'h1c

// ****************************************************************
// field positions
// ****************************************************************
`define FPCS_CTRL_BYTE     0
`define FPCS_CTRL_BYPASS   1
`define FPCS_ST_BUSY       0
`define FPCS_ST_REFUSED    1
`define FPCS_ST_MODE_LO    4
`define FPCS_ST_WAIT       8
`define FPCS_PW_RESET      64'hffff_ffff_ffff_ffff

// ****************************************************************
// command codes and unlock addresses
// ****************************************************************
`define FPCS_UA1_WORD    23'h000555
`define FPCS_UA2_WORD    23'h0002aa
`define FPCS_UA1_BYTE    23'h000aaa
`define FPCS_UA2_BYTE    23'h000555
`define FPCS_D_UNLOCK1   16'h00aa
`define FPCS_D_UNLOCK2   16'h0055
`define FPCS_D_EBP       16'h0033
`define FPCS_D_CONFIRM   16'h0029
`define FPCS_D_LOCKREG   16'h0040
`define FPCS_D_PASSWORD  16'h0060
`define FPCS_D_NVPROT    16'h00c0
`define FPCS_D_PROGRAM   16'h00a0
`define FPCS_D_ERASE     16'h0080
`define FPCS_D_CLEAR     16'h0030
`define FPCS_D_PWUNLOCK  16'h0025
`define FPCS_D_PWCOUNT   16'h0003
`define FPCS_D_EXT_ENTER 16'h0088
`define FPCS_D_EXIT1     16'h0090
`define FPCS_D_EXIT2     16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define FPCS_CLK_NS        10
`define FPCS_UNLOCK_GAP_NS 1000
`define FPCS_GAP_CYC       ((`FPCS_UNLOCK_GAP_NS + `FPCS_CLK_NS - 1) / `FPCS_CLK_NS)

`endif

/* hdl/fpcs_pkg.sv */
// types shared by the flash protection command-set host controller
// assumes fpcs_defines.svh for numeric constants
package fpcs_pkg;
    typedef enum logic [3:0] {
        FPCS_OP_WRITE, FPCS_OP_READ, FPCS_OP_EBP_START, FPCS_OP_EBP_CONFIRM,
        FPCS_OP_ENTER_EXT, FPCS_OP_EXIT_EXT, FPCS_OP_ENTER_LOCK, FPCS_OP_ENTER_PW,
        FPCS_OP_ENTER_NV, FPCS_OP_PROGRAM, FPCS_OP_CLEAR_NV, FPCS_OP_PW_UNLOCK,
        FPCS_OP_EXIT_PROT
    } fpcs_op_e;

    typedef enum logic [2:0] {
        FPCS_M_READ, FPCS_M_EXT, FPCS_M_LOCK, FPCS_M_PW, FPCS_M_NV
    } fpcs_mode_e;

    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] data;
        logic        rd;
        logic        last;
    } fpcs_step_s;
endpackage

/* hdl/fpcs_cyc_if.sv */
// one flash bus cycle request between the sequencer and the pin engine
// assumes a single clock domain
`timescale 1ns/1ns
interface fpcs_cyc_if;
    logic        req;
    logic        rd;
    logic [22:0] addr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
    modport ctl (output req, rd, addr, wdata, input done, rdata);
    modport eng (input req, rd, addr, wdata, output done, rdata);
endinterface

/* hdl/fpcs_bus_cycle.sv */
// drives one asynchronous flash write or read cycle on the pins
// assumes req holds with stable fields until done
`timescale 1ns/1ns
`include "fpcs_defines.svh"
module fpcs_bus_cycle #(
    parameter int SETUP_CYC = 2,
    parameter int PULSE_CYC = 4,
    parameter int HOLD_CYC  = 2
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    fpcs_cyc_if.eng          cyc,
    output logic [22:0]      fl_addr,
    output logic [15:0]      fl_dq_out,
    output logic             fl_dq_oe,
    input  wire logic [15:0] fl_dq_in,
    output logic             fl_ce_n,
    output logic             fl_oe_n,
    output logic             fl_we_n
);
    typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fpcs_eng_e;
    fpcs_eng_e   st_q;
    logic [7:0]  cnt_q;
    logic        rd_q;
    logic        done_q;
    logic [15:0] rdata_q;
    wire         cnt_zero = (cnt_q == 8'h00);
    // done blocks a restart in the cycle the sequencer is still dropping req
    wire         start    = (st_q == E_IDLE) && cyc.req && !done_q;

    assign cyc.done  = done_q;
    assign cyc.rdata = rdata_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= E_IDLE; cnt_q <= 8'h00; rd_q <= 1'b0; done_q <= 1'b0;
            rdata_q <= 16'h0000; fl_addr <= 23'h000000; fl_dq_out <= 16'h0000;
            fl_dq_oe <= 1'b0; fl_ce_n <= 1'b1; fl_oe_n <= 1'b1; fl_we_n <= 1'b1;
        end else begin
            done_q <= 1'b0;
            cnt_q  <= cnt_zero ? 8'h00 : cnt_q - 8'h01;
            unique case (st_q)
                E_IDLE: if (start) begin
                    st_q <= E_SETUP; cnt_q <= 8'(SETUP_CYC - 1); rd_q <= cyc.rd;
                    fl_addr <= cyc.addr; fl_dq_out <= cyc.wdata;
                    fl_dq_oe <= !cyc.rd; fl_ce_n <= 1'b0;
                end
                E_SETUP: if (cnt_zero) begin
                    st_q <= E_STROBE; cnt_q <= 8'(PULSE_CYC - 1);
                    fl_we_n <= rd_q; fl_oe_n <= !rd_q;
                end
                E_STROBE: if (cnt_zero) begin
                    st_q <= E_HOLD; cnt_q <= 8'(HOLD_CYC - 1);
                    if (rd_q) rdata_q <= fl_dq_in;
                    fl_we_n <= 1'b1; fl_oe_n <= 1'b1;
                end
                E_HOLD: if (cnt_zero) begin
                    st_q <= E_IDLE; fl_ce_n <= 1'b1; fl_dq_oe <= 1'b0; done_q <= 1'b1;
                end
            endcase
        end
    end

    a_no_drive_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        !(fl_dq_oe && !fl_oe_n)) else $error("data driven while flash outputs");
endmodule // fpcs_bus_cycle

/* hdl/fpcs_host.sv */
// host controller issuing protection and special-area command sets to a flash
// assumes an ahb-lite master with single word transfers and a word-mode flash by default (CTRL bit 0 selects byte-mode unlock addresses)
`timescale 1ns/1ns
`include "fpcs_defines.svh"
module fpcs_host
    import fpcs_pkg::*;
#(
    parameter int SETUP_CYC = 2,
    parameter int PULSE_CYC = 4,
    parameter int HOLD_CYC  = 2
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic [22:0]      fl_addr,
    output logic [15:0]      fl_dq_out,
    output logic             fl_dq_oe,
    input  wire logic [15:0] fl_dq_in,
    output logic             fl_ce_n,
    output logic             fl_oe_n,
    output logic             fl_we_n
);
    import fpcs_pkg::*;

    localparam int GAP_CYC = `FPCS_GAP_CYC;

    // ****************************************************************
    // ahb-lite slave
    // ****************************************************************
    logic [7:0]  wa_q;
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [7:0]  ra_q;
    logic [1:0]  ctrl_q;
    logic [22:0] addr_q;
    logic [15:0] data_q;
    logic [15:0] rdata_q;
    logic [63:0] pw_q;
    logic        refused_q;

    wire take     = hsel && htrans[1] && hready;
    wire wr_cmd   = wr_pend_q && (wa_q == `FPCS_OFS_CMD);
    wire wr_ctrl  = wr_pend_q && (wa_q == `FPCS_OFS_CTRL);
    wire wr_addr  = wr_pend_q && (wa_q == `FPCS_OFS_ADDR);
    wire wr_data  = wr_pend_q && (wa_q == `FPCS_OFS_DATA);
    wire wr_stat  = wr_pend_q && (wa_q == `FPCS_OFS_STATUS);
    wire wr_pwlo  = wr_pend_q && (wa_q == `FPCS_OFS_PW_LO);
    wire wr_pwhi  = wr_pend_q && (wa_q == `FPCS_OFS_PW_HI);

    // ****************************************************************
    // sequencer
    // ****************************************************************
    typedef enum logic [1:0] {S_IDLE, S_RUN, S_SETTLE} fpcs_seq_e;
    fpcs_seq_e   seq_q;
    fpcs_op_e    op_q;
    fpcs_mode_e  mode_q;
    logic [2:0]  step_q;
    logic        req_q;
    logic [15:0] gap_q;
    fpcs_cyc_if  cyc ();

    wire       busy     = (seq_q != S_IDLE);
    wire       byte_m   = ctrl_q[`FPCS_CTRL_BYTE];
    wire       bypass   = ctrl_q[`FPCS_CTRL_BYPASS];
    wire [22:0] ua1     = byte_m ? `FPCS_UA1_BYTE : `FPCS_UA1_WORD;
    wire [22:0] ua2     = byte_m ? `FPCS_UA2_BYTE : `FPCS_UA2_WORD;
    fpcs_op_e  new_op;
    assign new_op = fpcs_op_e'(hwdata[3:0]);
    wire       in_prot  = (mode_q == FPCS_M_LOCK) || (mode_q == FPCS_M_PW)
                          || (mode_q == FPCS_M_NV);
    wire       gap_run  = (gap_q != 16'h0000);

    // host-side mirror of the device's mode decoder
    logic op_ok;
    always_comb begin
        unique case (new_op)
            FPCS_OP_WRITE, FPCS_OP_READ: op_ok = 1'b1;
            FPCS_OP_EBP_START, FPCS_OP_EBP_CONFIRM:
                op_ok = !in_prot && !(mode_q == FPCS_M_EXT && bypass);
            FPCS_OP_ENTER_EXT, FPCS_OP_ENTER_LOCK, FPCS_OP_ENTER_PW, FPCS_OP_ENTER_NV:
                op_ok = (mode_q == FPCS_M_READ);
            FPCS_OP_EXIT_EXT:   op_ok = (mode_q == FPCS_M_EXT);
            FPCS_OP_EXIT_PROT:  op_ok = in_prot;
            FPCS_OP_PROGRAM:    op_ok = in_prot;
            FPCS_OP_CLEAR_NV:   op_ok = (mode_q == FPCS_M_NV);
            FPCS_OP_PW_UNLOCK:  op_ok = (mode_q == FPCS_M_PW) && !gap_run;
            default:            op_ok = 1'b0;
        endcase
    end
    wire cmd_go  = wr_cmd && !busy && op_ok;
    wire cmd_bad = wr_cmd && !cmd_go;

    // one bus cycle of the current op at the current step
    function automatic fpcs_step_s step_of(fpcs_op_e op, logic [2:0] s, logic [22:0] a,
                                           logic [15:0] d, logic [63:0] pw, logic byp,
                                           logic [22:0] u1, logic [22:0] u2);
        fpcs_step_s r;
        r = '{addr: a, data: d, rd: 1'b0, last: 1'b1};
        unique case (op)
            FPCS_OP_WRITE: ;
            FPCS_OP_READ: r.rd = 1'b1;
            FPCS_OP_EBP_START: begin
                if (byp || s == 3'h2) r.data = `FPCS_D_EBP;
                else begin
                    r.addr = (s == 3'h0) ? u1 : u2;
                    r.data = (s == 3'h0) ? `FPCS_D_UNLOCK1 : `FPCS_D_UNLOCK2;
                    r.last = 1'b0;
                end
            end
            FPCS_OP_EBP_CONFIRM: r.data = `FPCS_D_CONFIRM;
            FPCS_OP_ENTER_EXT, FPCS_OP_ENTER_LOCK, FPCS_OP_ENTER_PW, FPCS_OP_ENTER_NV,
            FPCS_OP_EXIT_EXT: begin
                r.addr = (s == 3'h1) ? u2 : u1;
                r.last = (op == FPCS_OP_EXIT_EXT) ? (s == 3'h3) : (s == 3'h2);
                unique case (s)
                    3'h0: r.data = `FPCS_D_UNLOCK1;
                    3'h1: r.data = `FPCS_D_UNLOCK2;
                    3'h2: r.data = (op == FPCS_OP_ENTER_EXT)  ? `FPCS_D_EXT_ENTER :
                                   (op == FPCS_OP_ENTER_LOCK) ? `FPCS_D_LOCKREG :
                                   (op == FPCS_OP_ENTER_PW)   ? `FPCS_D_PASSWORD :
                                   (op == FPCS_OP_ENTER_NV)   ? `FPCS_D_NVPROT :
                                                                `FPCS_D_EXIT1;
                    default: begin
                        r.addr = 23'h000000;
                        r.data = `FPCS_D_EXIT2;
                    end
                endcase
            end
            FPCS_OP_PROGRAM: if (s == 3'h0) begin
                r.data = `FPCS_D_PROGRAM;
                r.last = 1'b0;
            end
            FPCS_OP_CLEAR_NV: begin
                r.addr = 23'h000000;
                r.data = (s == 3'h0) ? `FPCS_D_ERASE : `FPCS_D_CLEAR;
                r.last = (s == 3'h1);
            end
            FPCS_OP_PW_UNLOCK: begin
                r.addr = 23'h000000;
                r.last = (s == 3'h6);
                unique case (s)
                    3'h0: r.data = `FPCS_D_PWUNLOCK;
                    3'h1: r.data = `FPCS_D_PWCOUNT;
                    3'h6: r.data = `FPCS_D_CONFIRM;
                    default: begin
                        r.addr = {21'h000000, 2'(s - 3'h2)};
                        r.data = pw[16*(s-3'h2) +: 16];
                    end
                endcase
            end
            FPCS_OP_EXIT_PROT: begin
                r.addr = 23'h000000;
                r.data = (s == 3'h0) ? `FPCS_D_EXIT1 : `FPCS_D_EXIT2;
                r.last = (s == 3'h1);
            end
            default: ;
        endcase
        return r;
    endfunction

    fpcs_step_s cur;
    assign cur       = step_of(op_q, step_q, addr_q, data_q, pw_q, bypass, ua1, ua2);
    assign cyc.req   = req_q;
    assign cyc.rd    = cur.rd;
    assign cyc.addr  = cur.addr;
    assign cyc.wdata = cur.data;
    wire   seq_end   = (seq_q == S_RUN) && cyc.done && cur.last;

    fpcs_mode_e mode_next;
    always_comb begin
        unique case (op_q)
            FPCS_OP_ENTER_EXT:  mode_next = FPCS_M_EXT;
            FPCS_OP_ENTER_LOCK: mode_next = FPCS_M_LOCK;
            FPCS_OP_ENTER_PW:   mode_next = FPCS_M_PW;
            FPCS_OP_ENTER_NV:   mode_next = FPCS_M_NV;
            FPCS_OP_EXIT_EXT, FPCS_OP_EXIT_PROT: mode_next = FPCS_M_READ;
            default:            mode_next = mode_q;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            seq_q <= S_IDLE; op_q <= FPCS_OP_WRITE; mode_q <= FPCS_M_READ;
            step_q <= 3'h0; req_q <= 1'b0; gap_q <= 16'h0000;
        end else begin
            gap_q <= gap_run ? gap_q - 16'h0001 : 16'h0000;
            unique case (seq_q)
                S_IDLE: if (cmd_go) begin
                    seq_q <= S_RUN; op_q <= new_op; step_q <= 3'h0; req_q <= 1'b1;
                end
                S_RUN: if (cyc.done) begin
                    step_q <= step_q + 3'h1;
                    if (cur.last) begin
                        req_q  <= 1'b0;
                        mode_q <= mode_next;
                        if (op_q == FPCS_OP_PW_UNLOCK) begin
                            seq_q <= S_SETTLE;
                            gap_q <= 16'(GAP_CYC);
                        end else seq_q <= S_IDLE;
                    end
                end
                S_SETTLE: if (!gap_run) seq_q <= S_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // register file and bus answers
    // ****************************************************************
    wire [31:0] status = {23'h000000, gap_run, 1'b0, mode_q, 2'b00, refused_q, busy};
    wire [31:0] rd_mux =
        (ra_q == `FPCS_OFS_CTRL)   ? {30'h00000000, ctrl_q} :
        (ra_q == `FPCS_OFS_CMD)    ? {28'h0000000, op_q} :
        (ra_q == `FPCS_OFS_ADDR)   ? {9'h000, addr_q} :
        (ra_q == `FPCS_OFS_DATA)   ? {16'h0000, data_q} :
        (ra_q == `FPCS_OFS_STATUS) ? status :
        (ra_q == `FPCS_OFS_RDATA)  ? {16'h0000, rdata_q} :
        (ra_q == `FPCS_OFS_PW_LO)  ? pw_q[31:0] :
        (ra_q == `FPCS_OFS_PW_HI)  ? pw_q[63:32] : 32'h00000000;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wa_q <= 8'h00; ra_q <= 8'h00; wr_pend_q <= 1'b0; rd_pend_q <= 1'b0;
            hreadyout <= 1'b1; hresp <= 1'b0; hrdata <= 32'h00000000;
        end else begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            if (take) begin
                wa_q <= haddr[7:0];
                ra_q <= haddr[7:0];
            end
            // one wait state so a read straight after a write sees the new value
            hreadyout <= !(take && !hwrite);
            if (rd_pend_q) hrdata <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= 2'b00; addr_q <= 23'h000000; data_q <= 16'h0000;
            rdata_q <= 16'h0000; pw_q <= `FPCS_PW_RESET; refused_q <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_q <= hwdata[1:0];
            if (wr_addr) addr_q <= hwdata[22:0];
            if (wr_data) data_q <= hwdata[15:0];
            if (wr_pwlo) pw_q[31:0]  <= hwdata;
            if (wr_pwhi) pw_q[63:32] <= hwdata;
            if ((seq_q == S_RUN) && cyc.done && cur.rd) rdata_q <= cyc.rdata;
            // set wins over the write-one clear
            if (cmd_bad) refused_q <= 1'b1;
            else if (wr_stat && hwdata[`FPCS_ST_REFUSED]) refused_q <= 1'b0;
        end
    end

    fpcs_bus_cycle #(
        .SETUP_CYC (SETUP_CYC),
        .PULSE_CYC (PULSE_CYC),
        .HOLD_CYC  (HOLD_CYC)
    ) u_cycle (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .cyc       (cyc),
        .fl_addr   (fl_addr),
        .fl_dq_out (fl_dq_out),
        .fl_dq_oe  (fl_dq_oe),
        .fl_dq_in  (fl_dq_in),
        .fl_ce_n   (fl_ce_n),
        .fl_oe_n   (fl_oe_n),
        .fl_we_n   (fl_we_n)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_unlock_done;
        seq_end && (op_q == FPCS_OP_PW_UNLOCK);
    endsequence

    a_unlock_settle: assert property (s_unlock_done |=> busy [*8])
        else $error("busy dropped before unlock settled");
    a_unlock_gap: assert property (s_unlock_done |=> gap_q == 16'(GAP_CYC))
        else $error("unlock gap timer not loaded");
    a_gap_refuse: assert property (wr_cmd && new_op == FPCS_OP_PW_UNLOCK && gap_run
        |-> !cmd_go) else $error("unlock accepted inside gap");
    a_enter_ext: assert property (seq_end && op_q == FPCS_OP_ENTER_EXT
        |=> mode_q == FPCS_M_EXT) else $error("extra block mode not entered");
    a_exit_prot: assert property (seq_end && op_q == FPCS_OP_EXIT_PROT
        |=> mode_q == FPCS_M_READ) else $error("protection exit kept mode");
    a_bypass_ext: assert property (cmd_go && mode_q == FPCS_M_EXT
        |-> !(bypass && new_op == FPCS_OP_EBP_START)) else $error("bypass in extra");
    a_enter_len: assert property (cmd_go && new_op == FPCS_OP_ENTER_NV
        |=> step_q == 3'h0 ##[1:300] (seq_end && step_q == 3'h2))
        else $error("enter sequence not three writes");
    a_exit_ext_len: assert property (seq_end && op_q == FPCS_OP_EXIT_EXT
        |-> step_q == 3'h3) else $error("extra exit not four writes");
    a_refuse_mode: assert property (cmd_bad && !busy |=> $stable(mode_q))
        else $error("ignored command changed mode");
    a_refused_flag: assert property (cmd_bad |=> refused_q)
        else $error("refused flag not set");
endmodule // fpcs_host

/* sim/fpcs_flash_model.sv */
// behavioural flash: mode entry and exit decoding, lock register store
// assumes one bus write per rising we_n while ce_n is low
`timescale 1ns/1ns
module fpcs_flash_model (
    input  wire logic [22:0] fl_addr,
    input  wire logic [15:0] fl_dq_out,
    input  wire logic        fl_ce_n,
    input  wire logic        fl_oe_n,
    input  wire logic        fl_we_n,
    input  wire logic        fl_dq_oe,
    output logic      [15:0] fl_dq_in
);
    logic [15:0] lock_q = 16'hffff;
    logic [15:0] last_d = 16'h0000;
    logic [15:0] held   = 16'h0000;
    logic [22:0] last_a = 23'h0;
    logic [2:0]  mode   = 3'h0;
    int          n_wr   = 0;
    logic [63:0] pw_m   = 64'hffff_ffff_ffff_ffff;
    logic [7:0]  guard  = 8'h00;
    int          n_bad  = 0;
    time         t_wr   = 0;
    wire  [15:0] rd_val = (mode == 3'h2) ? lock_q :
                          (mode == 3'h3) ? pw_m[16*fl_addr[1:0] +: 16] :
                          (mode == 3'h4) ? {15'h0000, guard[fl_addr[18:16]]} :
                          fl_addr[15:0];
    // a released bus shows the inverse of the last value, never a stale copy
    assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd_val : ~held;
    always @(posedge fl_oe_n) held = rd_val;
    always @(posedge fl_we_n) if (!fl_ce_n) begin
        n_wr++;
        t_wr = $time;
        if (fl_dq_oe !== 1'b1) n_bad++;
        if (mode == 3'h0 && last_d == 16'h0055) begin
            case (fl_dq_out)
                16'h0088: mode = 3'h1;
                16'h0040: mode = 3'h2;
                16'h0060: mode = 3'h3;
                16'h00c0: mode = 3'h4;
                default: ;
            endcase
        end
        if (last_d == 16'h0090 && fl_dq_out == 16'h0000) mode = 3'h0;
        if (last_d == 16'h00a0) begin
            // bit 0 guards the extra block and can never be cleared again
            if (mode == 3'h2) lock_q = fl_dq_out | (lock_q & 16'h0001);
            if (mode == 3'h3) pw_m[16*fl_addr[1:0] +: 16] = fl_dq_out;
            if (mode == 3'h4) guard[fl_addr[18:16]] = 1'b1;
        end
        // clear-all acts only in the protection set, never on the extra block
        if (mode == 3'h4 && last_d == 16'h0080) begin
            if (fl_dq_out == 16'h0030) guard = 8'h00;
        end
        last_d = fl_dq_out;
        last_a = fl_addr;
    end
endmodule  // fpcs_flash_model

/* sim/fpcs_host_test.sv */
// self-checking bench: ahb-lite master driving fpcs_host against a flash model
// assumes hready is the slave's own hreadyout
`timescale 1ns/1ns
`include "fpcs_defines.svh"
module fpcs_host_test;
    logic        sys_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdy_s = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_s = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    wire  [31:0] hrdata;
    wire  [22:0] fl_addr;
    wire  [15:0] fl_dq_out, fl_dq_in;
    wire         hreadyout, hresp, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
    int          miscompares = 0, n_tests = 0;
    fpcs_host u_fpcs_host (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fl_addr, .fl_dq_out,
        .fl_dq_oe, .fl_dq_in, .fl_ce_n, .fl_oe_n, .fl_we_n);
    fpcs_flash_model u_fpcs_flash_model (.fl_addr, .fl_dq_out, .fl_ce_n, .fl_oe_n, .fl_dq_oe,
        .fl_we_n, .fl_dq_in);
    initial forever #5 sys_clk = ~sys_clk;
    // values the next rising edge samples, free of same-step races
    always @(negedge sys_clk) begin
        rdy_s <= hreadyout;
        rd_s <= hrdata;
    end
    task automatic report_and_stop;
        if (miscompares == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wt;
        int i;
        i = 0;
        do begin @(posedge sys_clk); i++; end while (rdy_s !== 1'b1 && i < 2000);
        if (i >= 2000) begin chk("hready wait", 1, 0); report_and_stop; end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
        wt();
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        wt();
        q = rd_s;
    endtask
    task automatic op(input logic [3:0] o);
        logic [31:0] s;
        int i;
        xfer(1, `FPCS_OFS_CMD, {28'h0, o}, s);
        for (i = 0; i < 500; i++) begin
            xfer(0, `FPCS_OFS_STATUS, 0, s);
            if (s[`FPCS_ST_BUSY] === 1'b0) break;
        end
        if (i == 500) begin chk("busy wait", 0, 1); report_and_stop; end
    endtask
    task automatic st(input string nm, input logic [2:0] m, input logic r);
        logic [31:0] s;
        xfer(0, `FPCS_OFS_STATUS, 0, s);
        chk(nm, {28'h0, m, r}, {28'h0, s[6:4], s[1]});
        xfer(1, `FPCS_OFS_STATUS, 32'h2, s);
    endtask
    task automatic t_idle;
        logic [31:0] s;
        st("reset mode", 3'h0, 1'b0);
        xfer(0, 8'h20, 0, s);
        chk("unmapped", 0, s);
        chk("hresp", 0, {31'h0, hresp});
    endtask
    task automatic t_ebp;
        logic [31:0] s;
        int n;
        n = u_fpcs_flash_model.n_wr;
        xfer(1, `FPCS_OFS_ADDR, 32'h10000, s);
        op(4'h2);
        // 256 data words at block offsets 00 to ff, then confirm at offset 00
        for (int i = 0; i < 256; i++) begin
            xfer(1, `FPCS_OFS_ADDR, 32'h10000 + i, s);
            xfer(1, `FPCS_OFS_DATA, i, s);
            op(4'h0);
        end
        xfer(1, `FPCS_OFS_ADDR, 32'h10000, s);
        op(4'h3);
        chk("ebp writes", 260, u_fpcs_flash_model.n_wr - n);
        chk("confirm", 32'h29, {16'h0, u_fpcs_flash_model.last_d});
        chk("block addr", 32'h10000, {9'h0, u_fpcs_flash_model.last_a});
    endtask
    task automatic t_lock;
        logic [31:0] s;
        xfer(1, `FPCS_OFS_CTRL, 32'h1, s);
        op(4'h6);
        chk("byte unlock addr", 32'haaa, {9'h0, u_fpcs_flash_model.last_a});
        xfer(1, `FPCS_OFS_CTRL, 32'h0, s);
        st("lock entry", 3'h2, 1'b0);
        xfer(1, `FPCS_OFS_DATA, 32'h5, s);
        op(4'h9);
        chk("lock prog", 32'h5, {16'h0, u_fpcs_flash_model.lock_q});
        op(4'h1);
        xfer(0, `FPCS_OFS_RDATA, 0, s);
        chk("lock read", 32'h5, s);
        op(4'ha);
        st("clear in lock", 3'h2, 1'b1);
        op(4'hc);
        st("lock exit", 3'h0, 1'b0);
    endtask
    task automatic t_extra;
        logic [31:0] s;
        int n;
        op(4'h4);
        st("extra entry", 3'h1, 1'b0);
        xfer(1, `FPCS_OFS_CTRL, 32'h2, s);
        op(4'h2);
        st("bypass in extra", 3'h1, 1'b1);
        op(4'ha);
        st("erase in extra", 3'h1, 1'b1);
        xfer(1, `FPCS_OFS_CTRL, 32'h0, s);
        n = u_fpcs_flash_model.n_wr;
        op(4'h5);
        chk("exit writes", 4, u_fpcs_flash_model.n_wr - n);
        st("extra exit", 3'h0, 1'b0);
    endtask
    task automatic t_pw_nv;
        logic [31:0] s;
        int n;
        op(4'h7);
        st("pw entry", 3'h3, 1'b0);
        xfer(1, `FPCS_OFS_ADDR, 32'h2, s);
        op(4'h1);
        xfer(0, `FPCS_OFS_RDATA, 0, s);
        chk("pw blank", 32'hffff, s);
        for (int i = 0; i < 4; i++) begin
            xfer(1, `FPCS_OFS_ADDR, i, s);
            xfer(1, `FPCS_OFS_DATA, 32'h1230 + i, s);
            op(4'h9);
        end
        op(4'h1);
        xfer(0, `FPCS_OFS_RDATA, 0, s);
        chk("pw word", 32'h1233, s);
        n = u_fpcs_flash_model.n_wr;
        xfer(1, `FPCS_OFS_CMD, 32'hb, s);
        s = 32'h0;
        for (int i = 0; i < 500 && s[`FPCS_ST_WAIT] !== 1'b1; i++) begin
            xfer(0, `FPCS_OFS_STATUS, 0, s);
        end
        if (s[`FPCS_ST_WAIT] !== 1'b1) begin chk("gap wait", 1, 0); report_and_stop; end
        // a second unlock inside the 1 us gap must be refused
        op(4'hb);
        chk("unlock writes", 7, u_fpcs_flash_model.n_wr - n);
        chk("unlock settle", 1, {31'h0, ($time - u_fpcs_flash_model.t_wr) >= 1000});
        st("gap refuse", 3'h3, 1'b1);
        op(4'hc);
        op(4'h8);
        op(4'h4);
        st("nv refuse", 3'h4, 1'b1);
        xfer(1, `FPCS_OFS_ADDR, 32'h10000, s);
        xfer(1, `FPCS_OFS_DATA, 32'h0, s);
        op(4'h9);
        op(4'h1);
        xfer(0, `FPCS_OFS_RDATA, 0, s);
        chk("guard set", 32'h1, s);
        n = u_fpcs_flash_model.n_wr;
        op(4'ha);
        chk("clear writes", 2, u_fpcs_flash_model.n_wr - n);
        chk("clear code", 32'h30, {16'h0, u_fpcs_flash_model.last_d});
        op(4'h1);
        xfer(0, `FPCS_OFS_RDATA, 0, s);
        chk("guard clear", 32'h0, s);
        chk("dq drive", 0, u_fpcs_flash_model.n_bad);
        op(4'hc);
    endtask
    task automatic t_reset;
        op(4'h4);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        st("reset exit", 3'h0, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        t_idle();
        t_ebp();
        t_lock();
        t_extra();
        t_pw_nv();
        t_reset();
        report_and_stop();
    end
endmodule  // fpcs_host_test
